// ===== bench/lre_switch_model.sv
// Model of the switches and speed demand wired to the drive inputs
`timescale 1ns/1ps
module lre_switch_model (
  input  wire logic               clk,
  input  wire logic [7:0]         sw_set,
  input  wire logic signed [15:0] spd_set,
  output logic      [7:0]         dig_in = 8'h80,
  output logic signed [15:0]      spd_out = 16'sh0000
);
  // Contacts change only at clock edges, as a debounced input would
  always_ff @(posedge clk) begin
    dig_in  <= sw_set;
    spd_out <= spd_set;
  end
endmodule : lre_switch_model

// ===== bench/tb_top.sv
// Self-checking bench for the ladder rung evaluator
`timescale 1ns/1ps
module tb_top;
  import lre_pkg::*;
  logic               clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic               do1f = 1'b0;
  logic [3:0]         sel = 4'hF;
  logic [7:0]         adr = 8'h00, sw = 8'h80, dig;
  logic [31:0]        wdat = 32'h0, rdat, q;
  logic signed [15:0] spd = 16'sh0000, spd_in;
  logic               ack, fwd, rev, jen, jfw, jrv, flt, frs, pid, spm, do1, irq;
  logic [1:0]         tbl;
  int                 fail_count = 0, n_tests = 0, seed = 32'h961B, i;
  // Modified process PID ladder, plus table select and a NOR rung on output 1
  logic [31:0] rung [14] = '{32'h4C000028, 32'h32000014, 32'h33000015, 32'h64000026,
    32'h3502641D, 32'h36003712, 32'h36000006, 32'h37000005, 32'h38000017,
    32'h39000032, 32'h56000013, 32'h01000022, 32'h34000023, 32'h3903003C};
  wire [11:0] outs = {fwd, rev, jen, jfw, jrv, flt, frs, pid, spm, tbl, do1};

  always #2 clk = ~clk;

  lre_switch_model u_lre_switch_model (.clk(clk), .sw_set(sw), .spd_set(spd),
    .dig_in(dig), .spd_out(spd_in));
  lre_ladder_top u_lre_ladder_top (.CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .DIG_IN(dig), .SPEED_DEMAND(spd_in), .DO1_FIXED(do1f), .RUN_FWD(fwd),
    .RUN_REV(rev), .JOG_EN(jen), .JOG_FWD(jfw), .JOG_REV(jrv), .FAULT_TRIP(flt),
    .FAULT_RESET(frs), .PID_EN(pid), .SPEED_MODE(spm), .PARAM_TABLE(tbl),
    .DIG_OUT1(do1), .IRQ(irq));

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    sel <= s;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) begin
      fail_count++;
      results();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // Expected drive commands worked out from the ladder for given inputs
  function automatic logic [11:0] model(input logic [7:0] s, input int sp, input logic f);
    logic c;
    c = (sp < 0 ? -sp : sp) > 2000;
    return {s[0], s[1], s[4] | s[5], s[4], s[5], f, s[6], s[3] ^ c, c, 1'b0, s[2], ~s[7]};
  endfunction : model

  // Three scan ticks so the new inputs are seen by a whole scan
  task automatic apply(input logic [7:0] s, input int sp, input logic f);
    @(posedge clk);
    sw <= s;
    spd <= 16'(sp);
    repeat (750) @(posedge clk);
    chk("outputs", {20'h0, model(s, sp, f)}, {20'h0, outs});
  endtask : apply

  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    results();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, ADR_COMP_SRC, 32'h0);
    chk("comp_src", 32'h0000000A, q);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, q);
    do1f <= 1'b1;
    repeat (3) @(posedge clk);
    chk("do1 fixed", 32'h1, {31'h0, do1});
    for (i = 0; i < 14; i++) wb(1'b1, ADR_RUNG_BASE + 8'(4 * i), rung[i]);
    wb(1'b1, ADR_COMP_THR, 32'h000007D0);
    wb(1'b1, ADR_TMR_PRESET, 32'h00000005);
    wb(1'b1, ADR_IRQ_EN, 32'h00000001);
    wb(1'b1, ADR_CTRL, 32'h00000D03);
    $display("test setup done");
    apply(8'h80, 2000, 1'b0);
    apply(8'h80, -2001, 1'b0);
    for (i = 0; i < 8; i++) apply({1'b1, 7'($random(seed))}, $random(seed) % 4000, 1'b0);
    $display("test random scans done");
    // A short low pulse on input 8 stays below the preset; a long low then trips the fault
    apply(8'h00, 0, 1'b0);
    apply(8'h80, 0, 1'b0);
    apply(8'h00, 0, 1'b0);
    repeat (3000) @(posedge clk);
    chk("fault", {20'h0, model(8'h00, 0, 1'b1)}, {20'h0, outs});
    // Busy bit depends on where the read falls in the scan, so it is left out
    wb(1'b0, ADR_STATUS, 32'h0);
    chk("status", 32'h00101108, q & 32'hFFDFFFFF);
    chk("irq", 32'h1, {31'h0, irq});
    wb(1'b0, ADR_IRQ_STS, 32'h0);
    chk("irq_sts", 32'h00000007, q);
    wb(1'b1, ADR_IRQ_EN, 32'h0);
    repeat (3) @(posedge clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wb(1'b1, ADR_IRQ_EN, 32'h1);
    wb(1'b1, ADR_IRQ_CLR, 32'h1);
    repeat (3) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // Only byte lane 1 of the preset may change
    wb(1'b1, ADR_TMR_PRESET, 32'hFFFFFF00, 4'h2);
    wb(1'b0, ADR_TMR_PRESET, 32'h0);
    chk("preset bytes", 32'h0000FF05, q);
    $display("test timer fault done");
    results();
  end
endmodule : tb_top

// ===== src/lre_ladder_top.sv
// Ladder rung evaluator: bus registers, scan engine, comparator, timer, interrupt
`timescale 1ns/1ps

// Functional notes
// - Rung word bytes are condition one, operator, condition two, action, top down.
// - Rungs run in ascending order from first to last on each scan.
// - A variable set by an earlier rung is seen by later rungs.
// - Comparator is true when the chosen quantity exceeds the threshold.
// - Condition 76 reads the comparator; set-variable stores the result, 100 reads it.
// - Torque/speed action gives speed mode when true, torque mode when false.
// - Operator 2 is exclusive-OR; PID enable follows its result.
// - Start-timer holds the timer cleared while true and lets it count while false.
// - Timer condition is true once the count reaches the preset.
// - A start before the preset clears the timer, so no timeout occurs.
// - Operator 3 is NOR; fault with NOR of input 8 trips when low.
// - Condition 1 is always true, keeping table select under logic control.
// - Table bit 0 action drives the low bit of the table index.
// - Jog enable is the OR of its inputs; separate actions set direction.
// - Output 1 set to logic control is driven by the rung engine.
// - Table index bit 1 from action 36, bit 0 from 35; 0..3 selects 1..4.
module lre_ladder_top
  import lre_pkg::*;
(
  input  wire logic               CLK,
  input  wire logic               RST_N,
  input  wire logic               WB_CYC_I,
  input  wire logic               WB_STB_I,
  input  wire logic               WB_WE_I,
  input  wire logic [7:0]         WB_ADR_I,
  input  wire logic [3:0]         WB_SEL_I,
  input  wire logic [31:0]        WB_DAT_I,
  output logic      [31:0]        WB_DAT_O,
  output logic                    WB_ACK_O,
  input  wire logic [7:0]         DIG_IN,
  input  wire logic signed [15:0] SPEED_DEMAND,
  input  wire logic               DO1_FIXED,
  output logic                    RUN_FWD,
  output logic                    RUN_REV,
  output logic                    JOG_EN,
  output logic                    JOG_FWD,
  output logic                    JOG_REV,
  output logic                    FAULT_TRIP,
  output logic                    FAULT_RESET,
  output logic                    PID_EN,
  output logic                    SPEED_MODE,
  output logic      [1:0]         PARAM_TABLE,
  output logic                    DIG_OUT1,
  output logic                    IRQ
);
  logic [31:0]         ctrl_q;
  logic [7:0]          comp_src_q;
  logic [15:0]         comp_thr_q;
  logic [31:0]         tmr_preset_q;
  logic [31:0]         tmr_cnt_q;
  logic [2:0]          irq_sts_q;
  logic [2:0]          irq_en_q;
  logic                wb_busy_q;
  logic [31:0]         rd_mux;
  logic [31:0]         bmask;
  logic [31:0]         mem_rdata_a;
  logic [31:0]         mem_rdata_b;
  logic                wb_req;
  logic                wb_wr;
  logic                in_win;
  lre_state_e          state_q;
  logic [RUNG_AW-1:0]  idx_q;
  logic [7:0]          tick_cnt_q;
  logic                tick;
  logic                run;
  logic                last;
  logic                eval;
  logic [AB_W-1:0]     act_q;
  logic [AB_W-1:0]     out_q;
  logic [3:0]          var_q;
  logic                comp_q;
  logic                tmr_done;
  logic                tmr_done_d_q;
  logic [7:0]          r_c1;
  logic [7:0]          r_op;
  logic [7:0]          r_c2;
  logic [7:0]          r_act;
  logic                c1v;
  logic                c2v;
  logic                result;
  logic                act_hit;
  logic [3:0]          act_idx;
  logic                var_hit;
  logic [7:0]          var_off;
  logic                tmr_start;
  logic signed [16:0]  spd_ext;
  logic signed [16:0]  qty;
  logic [2:0]          irq_ev;
  logic [2:0]          irq_clr;

  assign wb_req = WB_CYC_I && WB_STB_I;
  assign wb_wr  = wb_busy_q && WB_WE_I;
  assign in_win = WB_ADR_I >= ADR_RUNG_BASE;
  assign bmask  = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  assign run    = ctrl_q[CTRL_RUN_BIT];
  assign eval   = state_q == ST_EVAL;
  assign tick   = tick_cnt_q == SCAN_TICK_CYC - 8'h01;
  assign last   = idx_q == ctrl_q[CTRL_LAST_LSB +: RUNG_AW];

  lre_rung_mem u_mem (
    .clk     (CLK),
    .we      (wb_wr && in_win),
    .be      (WB_SEL_I),
    .waddr   (WB_ADR_I[RUNG_AW+1:2]),
    .wdata   (WB_DAT_I),
    .raddr_a (idx_q),
    .rdata_a (mem_rdata_a),
    .raddr_b (WB_ADR_I[RUNG_AW+1:2]),
    .rdata_b (mem_rdata_b)
  );

  // Two-cycle answer: the memory read port needs one registered stage
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wb_busy_q <= 1'b0;
      WB_ACK_O  <= 1'b0;
      WB_DAT_O  <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= 1'b0;
      if (wb_busy_q) begin
        wb_busy_q <= 1'b0;
        WB_ACK_O  <= 1'b1;
        WB_DAT_O  <= rd_mux;
      end else if (wb_req && !WB_ACK_O) begin
        wb_busy_q <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (in_win) begin
      rd_mux = mem_rdata_b;
    end else begin
      case (WB_ADR_I)
        ADR_CTRL:       rd_mux = ctrl_q;
        ADR_STATUS: begin
          rd_mux[AB_W-1:0]          = out_q;
          rd_mux[STS_VAR_LSB +: 4]  = var_q;
          rd_mux[STS_TMR_BIT]       = tmr_done;
          rd_mux[STS_BUSY_BIT]      = state_q != ST_IDLE;
        end
        ADR_COMP_SRC:   rd_mux[7:0] = comp_src_q;
        ADR_COMP_THR:   rd_mux[15:0] = comp_thr_q;
        ADR_TMR_PRESET: rd_mux = tmr_preset_q;
        ADR_IRQ_STS:    rd_mux[2:0] = irq_sts_q;
        ADR_IRQ_EN:     rd_mux[2:0] = irq_en_q;
        ADR_TMR_COUNT:  rd_mux = tmr_cnt_q;
        default:        rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctrl_q       <= CTRL_RST;
      comp_src_q   <= COMP_SRC_RST;
      comp_thr_q   <= COMP_THR_RST;
      tmr_preset_q <= TMR_PRESET_RST;
      irq_en_q     <= IRQ_EN_RST;
    end else if (wb_wr && !in_win) begin
      case (WB_ADR_I)
        ADR_CTRL:       ctrl_q <= ((ctrl_q & ~bmask) | (WB_DAT_I & bmask)) & CTRL_MASK;
        ADR_COMP_SRC:   comp_src_q <= WB_SEL_I[0] ? WB_DAT_I[7:0] : comp_src_q;
        ADR_COMP_THR:   comp_thr_q <= 16'((comp_thr_q & ~bmask) | (WB_DAT_I & bmask));
        ADR_TMR_PRESET: tmr_preset_q <= (tmr_preset_q & ~bmask) | (WB_DAT_I & bmask);
        ADR_IRQ_EN:     irq_en_q <= WB_SEL_I[0] ? WB_DAT_I[2:0] : irq_en_q;
        default:        ctrl_q <= ctrl_q;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tick_cnt_q <= 8'h00;
    end else begin
      tick_cnt_q <= tick ? 8'h00 : tick_cnt_q + 8'h01;
    end
  end

  // A scan of all rungs fits well inside one tick, so a tick never meets a busy engine
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_q <= ST_IDLE;
      idx_q   <= '0;
    end else if (!run) begin
      state_q <= ST_IDLE;
      idx_q   <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (tick) begin
            state_q <= ST_FETCH;
            idx_q   <= '0;
          end
        end
        ST_FETCH: state_q <= ST_EVAL;
        ST_EVAL: begin
          if (last) begin
            state_q <= ST_DONE;
          end else begin
            state_q <= ST_FETCH;
            idx_q   <= idx_q + 1'b1;
          end
        end
        ST_DONE: state_q <= ST_IDLE;
      endcase
    end
  end

  assign r_c1  = mem_rdata_a[RUNG_C1_LSB +: 8];
  assign r_op  = mem_rdata_a[RUNG_OP_LSB +: 8];
  assign r_c2  = mem_rdata_a[RUNG_C2_LSB +: 8];
  assign r_act = mem_rdata_a[RUNG_ACT_LSB +: 8];

  // Variables read here are already updated by earlier rungs of this scan
  function automatic logic cond_val(input logic [7:0] code);
    logic [7:0] off_in;
    logic [7:0] off_var;
    off_in   = code - COND_IN1;
    off_var  = code - COND_VAR_A;
    cond_val = 1'b0;
    if (code == COND_TRUE) begin
      cond_val = 1'b1;
    end else if (code == COND_COMP_A) begin
      cond_val = comp_q;
    end else if (code == COND_TMR_A) begin
      cond_val = tmr_done;
    end else if (code >= COND_IN1 && code <= COND_IN8) begin
      cond_val = DIG_IN[off_in[2:0]];
    end else if (code >= COND_VAR_A && code <= COND_VAR_D) begin
      cond_val = var_q[off_var[1:0]];
    end
  endfunction : cond_val

  assign c1v = cond_val(r_c1);
  assign c2v = cond_val(r_c2);

  always_comb begin
    unique case (r_op)
      OP_OR:   result = c1v | c2v;
      OP_AND:  result = c1v & c2v;
      OP_XOR:  result = c1v ^ c2v;
      OP_NOR:  result = ~(c1v | c2v);
      default: result = 1'b0;
    endcase
  end

  always_comb begin
    act_hit = 1'b1;
    act_idx = AB_JOG_REV;
    unique case (r_act)
      ACT_JOG_REV: act_idx = AB_JOG_REV;
      ACT_JOG_FWD: act_idx = AB_JOG_FWD;
      ACT_JOG_EN:  act_idx = AB_JOG_EN;
      ACT_FAULT:   act_idx = AB_FAULT;
      ACT_FWD:     act_idx = AB_FWD;
      ACT_REV:     act_idx = AB_REV;
      ACT_RESET:   act_idx = AB_RESET;
      ACT_PID:     act_idx = AB_PID;
      ACT_TBL_EN:  act_idx = AB_TBL_EN;
      ACT_TBL0:    act_idx = AB_TBL0;
      ACT_TBL1:    act_idx = AB_TBL1;
      ACT_SPEED:   act_idx = AB_SPEED;
      ACT_DO1:     act_idx = AB_DO1;
      default:     act_hit = 1'b0;
    endcase
  end

  assign var_off   = r_act - ACT_VAR_A;
  assign var_hit   = r_act >= ACT_VAR_A && r_act <= ACT_VAR_D;
  assign tmr_start = r_act == ACT_TMR_START;

  // Action bits settle during the scan and reach the pins only at its end
  always_ff @(posedge CLK) begin
    if (!RST_N || !run) begin
      act_q <= '0;
      var_q <= 4'h0;
    end else if (eval) begin
      if (act_hit) begin
        act_q[act_idx] <= result;
      end
      if (var_hit) begin
        var_q[var_off[1:0]] <= result;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      out_q       <= '0;
      PARAM_TABLE <= 2'b00;
    end else if (!run) begin
      out_q       <= '0;
      PARAM_TABLE <= 2'b00;
    end else if (state_q == ST_DONE) begin
      out_q       <= act_q;
      PARAM_TABLE <= act_q[AB_TBL_EN] ? {act_q[AB_TBL1], act_q[AB_TBL0]} : 2'b00;
    end
  end

  assign RUN_FWD     = out_q[AB_FWD];
  assign RUN_REV     = out_q[AB_REV];
  assign JOG_EN      = out_q[AB_JOG_EN];
  assign JOG_FWD     = out_q[AB_JOG_FWD];
  assign JOG_REV     = out_q[AB_JOG_REV];
  assign FAULT_TRIP  = out_q[AB_FAULT];
  assign FAULT_RESET = out_q[AB_RESET];
  assign PID_EN      = out_q[AB_PID];
  assign SPEED_MODE  = out_q[AB_SPEED];

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      DIG_OUT1 <= 1'b0;
    end else if (!ctrl_q[CTRL_DO1_BIT]) begin
      DIG_OUT1 <= DO1_FIXED;
    end else if (state_q == ST_DONE) begin
      DIG_OUT1 <= act_q[AB_DO1];
    end
  end

  // Threshold and quantity share units of 0.01 percent of the maximum
  assign spd_ext = 17'(SPEED_DEMAND);
  always_comb begin
    qty = 17'sh0;
    if (comp_src_q == SRC_ABS_SPEED) begin
      qty = spd_ext[16] ? -spd_ext : spd_ext;
    end else if (comp_src_q == SRC_SPEED) begin
      qty = spd_ext;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      comp_q <= 1'b0;
    end else begin
      comp_q <= qty > $signed({comp_thr_q[15], comp_thr_q});
    end
  end

  assign tmr_done = run && (tmr_cnt_q >= tmr_preset_q);

  // Saturating tick counter; a true start rung wins over the tick
  always_ff @(posedge CLK) begin
    if (!RST_N || !run) begin
      tmr_cnt_q <= 32'h0000_0000;
    end else if (eval && tmr_start && result) begin
      tmr_cnt_q <= 32'h0000_0000;
    end else if (tick && tmr_cnt_q != 32'hFFFF_FFFF) begin
      tmr_cnt_q <= tmr_cnt_q + 32'h0000_0001;
    end
  end

  assign irq_ev[IRQ_FAULT] = state_q == ST_DONE && act_q[AB_FAULT] && !out_q[AB_FAULT];
  assign irq_ev[IRQ_TMR]   = tmr_done && !tmr_done_d_q;
  assign irq_ev[IRQ_SCAN]  = state_q == ST_DONE;
  assign irq_clr = (wb_wr && WB_ADR_I == ADR_IRQ_CLR && WB_SEL_I[0]) ? WB_DAT_I[2:0] : 3'h0;

  // A new event in the clearing cycle keeps its bit set
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      irq_sts_q    <= 3'h0;
      tmr_done_d_q <= 1'b0;
      IRQ          <= 1'b0;
    end else begin
      irq_sts_q    <= (irq_sts_q & ~irq_clr) | irq_ev;
      tmr_done_d_q <= tmr_done;
      IRQ          <= |(irq_sts_q & irq_en_q);
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  wb_ack_lat_a: assert property (wb_req && !wb_busy_q && !WB_ACK_O |=> ##1 WB_ACK_O)
    else $error("bus answer not two cycles after request");
  rung_order_a: assert property (
    eval && !last && run |=> state_q == ST_FETCH && idx_q == 5'($past(idx_q) + 5'h01))
    else $error("rungs not taken in ascending order");
  var_same_scan_a: assert property (
    eval && var_hit && run |=> ##1 var_q[$past(var_off[1:0], 2)] == $past(result, 2))
    else $error("variable not updated for later rungs");
  xor_pid_a: assert property (
    eval && run && r_op == OP_XOR && r_act == ACT_PID |=> act_q[AB_PID] == $past(c1v ^ c2v))
    else $error("pid action not the xor of its conditions");
  nor_fault_a: assert property (
    eval && run && r_op == OP_NOR && r_act == ACT_FAULT |=> act_q[AB_FAULT] == !$past(c1v | c2v))
    else $error("fault action not the nor of its conditions");
  jog_or_a: assert property (
    eval && run && r_op == OP_OR && r_act == ACT_JOG_EN |=> act_q[AB_JOG_EN] == $past(c1v | c2v))
    else $error("jog enable not the or of its conditions");
  timer_clear_a: assert property (
    eval && run && tmr_start && result |=> tmr_cnt_q == 32'h0000_0000)
    else $error("start rung did not clear the timer");
  timer_tick_a: assert property (
    run && tick && !eval && tmr_cnt_q != 32'hFFFF_FFFF && $past(run) && ctrl_q[CTRL_RUN_BIT]
    |=> run |-> tmr_cnt_q == $past(tmr_cnt_q) + 32'h0000_0001)
    else $error("timer did not advance on a scan tick");
  timer_fault_a: assert property (
    eval && run && r_c1 == COND_TMR_A && r_op == OP_OR && r_act == ACT_FAULT && r_c2 == 8'h00
    |=> act_q[AB_FAULT] == $past(tmr_cnt_q >= tmr_preset_q))
    else $error("timer condition does not follow the preset");
  table_sel_a: assert property (
    state_q == ST_DONE && run |=> PARAM_TABLE ==
      ($past(act_q[AB_TBL_EN]) ? {$past(act_q[AB_TBL1]), $past(act_q[AB_TBL0])} : 2'b00))
    else $error("parameter table index wrong");
  speed_mode_a: assert property (
    state_q == ST_DONE && run |=> SPEED_MODE == $past(act_q[AB_SPEED]))
    else $error("speed mode not taken from its rung");
  dig_out1_a: assert property (
    state_q == ST_DONE && ctrl_q[CTRL_DO1_BIT] |=> DIG_OUT1 == $past(act_q[AB_DO1]))
    else $error("output 1 not driven by the rungs");

  timer_clear_c: cover property (eval && tmr_start && result && tmr_cnt_q != 32'h0000_0000);
  timer_fault_c: cover property (state_q == ST_DONE && act_q[AB_FAULT] && tmr_done);
  table_sel_c:   cover property (PARAM_TABLE == 2'b11);
  irq_c:         cover property (IRQ && WB_ACK_O);
endmodule : lre_ladder_top

// ===== src/lre_pkg.sv
// Constants, register map and types of the ladder rung evaluator
package lre_pkg;
  localparam int unsigned RUNG_NUM = 32;
  localparam int unsigned RUNG_AW  = 5;
  // Register byte offsets
  localparam logic [7:0] ADR_CTRL       = 8'h00;
  localparam logic [7:0] ADR_STATUS     = 8'h04;
  localparam logic [7:0] ADR_COMP_SRC   = 8'h08;
  localparam logic [7:0] ADR_COMP_THR   = 8'h0C;
  localparam logic [7:0] ADR_TMR_PRESET = 8'h10;
  localparam logic [7:0] ADR_IRQ_STS    = 8'h14;
  localparam logic [7:0] ADR_IRQ_EN     = 8'h18;
  localparam logic [7:0] ADR_IRQ_CLR    = 8'h1C;
  localparam logic [7:0] ADR_TMR_COUNT  = 8'h20;
  localparam logic [7:0] ADR_RUNG_BASE  = 8'h80;
  // Control fields
  localparam int unsigned CTRL_RUN_BIT  = 0;
  localparam int unsigned CTRL_DO1_BIT  = 1;
  localparam int unsigned CTRL_LAST_LSB = 8;
  localparam logic [31:0] CTRL_MASK     = 32'h0000_1F03;
  // Status fields
  localparam int unsigned STS_VAR_LSB  = 16;
  localparam int unsigned STS_TMR_BIT  = 20;
  localparam int unsigned STS_BUSY_BIT = 21;
  // Reset values
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
  localparam logic [7:0]  COMP_SRC_RST   = 8'h0A;
  localparam logic [15:0] COMP_THR_RST   = 16'h0000;
  localparam logic [31:0] TMR_PRESET_RST = 32'h0000_0000;
  localparam logic [2:0]  IRQ_EN_RST     = 3'h0;
  // Rung word byte lanes
  localparam int unsigned RUNG_C1_LSB  = 24;
  localparam int unsigned RUNG_OP_LSB  = 16;
  localparam int unsigned RUNG_C2_LSB  = 8;
  localparam int unsigned RUNG_ACT_LSB = 0;
  // Condition codes
  localparam logic [7:0] COND_TRUE   = 8'h01;
  localparam logic [7:0] COND_IN1    = 8'h32;
  localparam logic [7:0] COND_IN8    = 8'h39;
  localparam logic [7:0] COND_COMP_A = 8'h4C;
  localparam logic [7:0] COND_TMR_A  = 8'h56;
  localparam logic [7:0] COND_VAR_A  = 8'h64;
  localparam logic [7:0] COND_VAR_D  = 8'h67;
  // Logic operators
  localparam logic [7:0] OP_OR  = 8'h00;
  localparam logic [7:0] OP_AND = 8'h01;
  localparam logic [7:0] OP_XOR = 8'h02;
  localparam logic [7:0] OP_NOR = 8'h03;
  // Action codes
  localparam logic [7:0] ACT_JOG_REV   = 8'h05;
  localparam logic [7:0] ACT_JOG_FWD   = 8'h06;
  localparam logic [7:0] ACT_JOG_EN    = 8'h12;
  localparam logic [7:0] ACT_FAULT     = 8'h13;
  localparam logic [7:0] ACT_FWD       = 8'h14;
  localparam logic [7:0] ACT_REV       = 8'h15;
  localparam logic [7:0] ACT_RESET     = 8'h17;
  localparam logic [7:0] ACT_PID       = 8'h1D;
  localparam logic [7:0] ACT_TBL_EN    = 8'h22;
  localparam logic [7:0] ACT_TBL0      = 8'h23;
  localparam logic [7:0] ACT_TBL1      = 8'h24;
  localparam logic [7:0] ACT_SPEED     = 8'h26;
  localparam logic [7:0] ACT_VAR_A     = 8'h28;
  localparam logic [7:0] ACT_VAR_D     = 8'h2B;
  localparam logic [7:0] ACT_TMR_START = 8'h32;
  localparam logic [7:0] ACT_DO1       = 8'h3C;
  // Bit positions in the action vector
  localparam int unsigned AB_W = 13;
  localparam logic [3:0] AB_JOG_REV = 4'h0;
  localparam logic [3:0] AB_JOG_FWD = 4'h1;
  localparam logic [3:0] AB_JOG_EN  = 4'h2;
  localparam logic [3:0] AB_FAULT   = 4'h3;
  localparam logic [3:0] AB_FWD     = 4'h4;
  localparam logic [3:0] AB_REV     = 4'h5;
  localparam logic [3:0] AB_RESET   = 4'h6;
  localparam logic [3:0] AB_PID     = 4'h7;
  localparam logic [3:0] AB_TBL_EN  = 4'h8;
  localparam logic [3:0] AB_TBL0    = 4'h9;
  localparam logic [3:0] AB_TBL1    = 4'hA;
  localparam logic [3:0] AB_SPEED   = 4'hB;
  localparam logic [3:0] AB_DO1     = 4'hC;
  // Comparator sources
  localparam logic [7:0] SRC_ABS_SPEED = 8'h0A;
  localparam logic [7:0] SRC_SPEED     = 8'h0B;
  // Interrupt bits
  localparam int unsigned IRQ_FAULT = 0;
  localparam int unsigned IRQ_TMR   = 1;
  localparam int unsigned IRQ_SCAN  = 2;
  // Scan timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned SCAN_TICK_NS  = 1000;
  localparam logic [7:0]  SCAN_TICK_CYC = 8'(SCAN_TICK_NS / CLK_PERIOD_NS);

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EVAL, ST_DONE} lre_state_e;
endpackage : lre_pkg

// ===== src/lre_rung_mem.sv
// Rung word store: byte-writable, two registered read ports
`timescale 1ns/1ps
module lre_rung_mem
  import lre_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               we,
  input  wire logic [3:0]         be,
  input  wire logic [RUNG_AW-1:0] waddr,
  input  wire logic [31:0]        wdata,
  input  wire logic [RUNG_AW-1:0] raddr_a,
  output logic      [31:0]        rdata_a,
  input  wire logic [RUNG_AW-1:0] raddr_b,
  output logic      [31:0]        rdata_b
);
  logic [31:0] mem_q [RUNG_NUM];

  always_ff @(posedge clk) begin
    for (int b = 0; b < 4; b++) begin
      if (we && be[b]) begin
        mem_q[waddr][8*b +: 8] <= wdata[8*b +: 8];
      end
    end
  end

  // Port a feeds the scan engine, port b the bus
  always_ff @(posedge clk) begin
    rdata_a <= mem_q[raddr_a];
    rdata_b <= mem_q[raddr_b];
  end
endmodule : lre_rung_mem
